// file: dv/mtm_timer_chk.sv
/*
 * Port checker for the modulo timer: bus timing, read-zero bits and irq.
 * Assumes hready is the slave's own hreadyout and status_control sits at 0x00.
 */
`timescale 1ns/1ps
module mtm_timer_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [mtm_pkg::HADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [mtm_pkg::HDATA_W-1:0] hrdata,
	input wire logic overflow_irq
);
	import mtm_pkg::*;
	logic take;
	assign take = hsel && htrans[1] && hready;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("hresp not okay");
	a_rdata_upper: assert property (hrdata[31:8] == 24'h000000)
		else $error("hrdata upper bits set");
	a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_write_nowait: assert property (take && hwrite |=> hreadyout)
		else $error("write stalled");
	a_rdata_hold: assert property (!$stable(hrdata) |-> !$past(hreadyout))
		else $error("hrdata changed outside a read");
	a_unmapped_zero: assert property (
		take && !hwrite && (haddr[31:5] != 27'h0 || haddr[4:2] > 3'h5)
		|-> ##2 hrdata == 32'h00000000)
		else $error("unmapped read not zero");
	a_sc_unused: assert property (
		take && !hwrite && haddr == 32'h00000000 |-> ##2 hrdata[5] == 1'b0 && hrdata[3:0] == 4'h0)
		else $error("status unused bits set");
	a_clk_unused: assert property (
		take && !hwrite && haddr == 32'h00000004 |-> ##2 hrdata[7:6] == 2'h0)
		else $error("clock config unused bits set");
	a_irq_status: assert property (
		take && !hwrite && haddr == 32'h00000000
		|-> ##2 overflow_irq == (hrdata[FLAG_BIT] && hrdata[IRQEN_BIT]))
		else $error("irq differs from flag and enable");
endmodule : mtm_timer_chk

// file: dv/testbench.sv
/*
 * Self-checking bench for the modulo timer over AHB-Lite.
 * Assumes the hand-over register map and one 40 MHz clock.
 */
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
	$display("mismatch %s exp %h got %h", n, e, g); end end
module testbench;
	import mtm_pkg::*;
	logic hclk, hresetn, hsel, hwrite, dbg_halt, fclk;
	logic [31:0] haddr, hwdata;
	logic [1:0] htrans;
	logic [3:0] ph;
	wire logic hreadyout, hresp, irq;
	wire logic [31:0] hrdata;
	int fail_count = 0;
	int tests_run = 0;
	logic [7:0] d;
	logic [15:0] v1, v2;
	logic [7:0] cv [13] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
		8'h0f, 8'h10, 8'h20, 8'h30};
	int dv [13] = '{1, 2, 4, 8, 16, 32, 64, 128, 256, 256, 8, 8, 8};
	mtm_timer i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.debug_halt_mode(dbg_halt), .fixed_freq_clock(fclk), .ext_count_input(fclk),
		.overflow_irq(irq));
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	// Slow side clock, an eighth of hclk, within the external input limit
	always @(posedge hclk) begin
		ph <= ph + 4'h1;
		if (ph[1:0] == 2'h3) fclk <= ~fclk;
	end
	task xfer(input logic [IDX_W-1:0] i, input logic w, input logic [7:0] wd,
		output logic [7:0] q);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {27'h0, i, 2'h0};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata[7:0];
	endtask : xfer
	task wr(input logic [IDX_W-1:0] i, input logic [7:0] wd);
		logic [7:0] q;
		xfer(i, 1'b1, wd, q);
	endtask : wr
	task rd(input logic [IDX_W-1:0] i, output logic [7:0] q);
		xfer(i, 1'b0, 8'h00, q);
	endtask : rd
	task cnt(output logic [15:0] q);
		rd(IDX_COUNT_HIGH_BYTE, q[15:8]);
		rd(IDX_COUNT_LOW_BYTE, q[7:0]);
	endtask : cnt
	task wait_flag;
		d = 8'h00;
		for (int k = 0; k < 100 && d[7] !== 1'b1; k++) rd(IDX_SC, d);
		`CHK("flag_set", 1'b1, d[7])
	endtask : wait_flag
	task complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run
	initial begin
		repeat (60000) @(posedge hclk);
		fail_count++;
		complete_run();
	end
	initial begin
		{hresetn, hsel, hwrite, dbg_halt, fclk} = 5'h0;
		{haddr, hwdata, htrans, ph} = '0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		rd(IDX_SC, d);
		`CHK("sc_reset", 8'h10, d)
		rd(IDX_CLK, d);
		`CHK("clk_reset", 8'h00, d)
		cnt(v1);
		`CHK("cnt_reset", 16'h0000, v1)
		rd(IDX_MODULO_HIGH_BYTE, d);
		`CHK("modulo_high_byte_reset", 8'h00, d)
		wr(IDX_COUNT_LOW_BYTE, 8'h55);
		rd(IDX_COUNT_LOW_BYTE, d);
		`CHK("cnt_ro", 8'h00, d)
		wr(3'h7, 8'h5a);
		rd(3'h7, d);
		`CHK("unmapped", 8'h00, d)
		wr(IDX_CLK, 8'hff);
		rd(IDX_CLK, d);
		`CHK("clk_unused", 8'h3f, d)
		wr(IDX_CLK, 8'h00);
		wr(IDX_MODULO_HIGH_BYTE, 8'h00);
		wr(IDX_MODULO_LOW_BYTE, 8'h10);
		rd(IDX_MODULO_LOW_BYTE, d);
		`CHK("mod_first", 8'h10, d)
		wr(IDX_SC, 8'h00);
		wait_flag();
		wr(IDX_SC, 8'h10);
		rd(IDX_SC, d);
		`CHK("flag_clear", 8'h10, d)
		cnt(v1);
		cnt(v2);
		`CHK("halt_freeze", v1, v2)
		`CHK("cnt_modulo", 1'b1, v1 <= 16'h0010)
		wr(IDX_SC, 8'h00);
		wait_flag();
		wr(IDX_SC, 8'h80);
		rd(IDX_SC, d);
		`CHK("write_one", 1'b1, d[7])
		rd(IDX_SC, d);
		repeat (40) @(posedge hclk);
		wr(IDX_SC, 8'h00);
		rd(IDX_SC, d);
		`CHK("clear_cancel", 1'b1, d[7])
		wr(IDX_SC, 8'h30);
		rd(IDX_SC, d);
		`CHK("cclr_flag", 8'h10, d)
		cnt(v1);
		`CHK("cclr_cnt", 16'h0000, v1)
		wr(IDX_SC, 8'h40);
		for (int k = 0; k < 100 && irq !== 1'b1; k++) @(posedge hclk);
		`CHK("irq_on", 1'b1, irq)
		rd(IDX_SC, d);
		wr(IDX_SC, 8'h50);
		repeat (2) @(posedge hclk);
		`CHK("irq_off", 1'b0, irq)
		wr(IDX_MODULO_HIGH_BYTE, 8'h00);
		wr(IDX_MODULO_LOW_BYTE, 8'h00);
		wr(IDX_SC, 8'h30);
		rd(IDX_MODULO_LOW_BYTE, d);
		`CHK("mod_free", 8'h00, d)
		// Latch low byte early; the high byte must come from the same snapshot
		wr(IDX_SC, 8'h00);
		rd(IDX_COUNT_LOW_BYTE, v1[7:0]);
		repeat (300) @(posedge hclk);
		rd(IDX_COUNT_HIGH_BYTE, v1[15:8]);
		wr(IDX_SC, 8'h10);
		cnt(v2);
		`CHK("coherent", 1'b1, (v2 - v1 >= 16'd300) && (v2 - v1 <= 16'd315))
		for (int i = 0; i < 13; i++) begin
			wr(IDX_CLK, cv[i]);
			wr(IDX_SC, 8'h30);
			wr(IDX_SC, 8'h00);
			repeat (512) @(posedge hclk);
			wr(IDX_SC, 8'h10);
			cnt(v1);
			`CHK("rate", 1'b1, (v1 + 2 >= 512 / dv[i]) && (v1 <= 512 / dv[i] + 3))
		end
		wr(IDX_CLK, 8'h00);
		wr(IDX_SC, 8'h30);
		wr(IDX_SC, 8'h00);
		repeat (100) @(posedge hclk);
		wr(IDX_CLK, 8'h11);
		repeat (100) @(posedge hclk);
		wr(IDX_SC, 8'h10);
		cnt(v1);
		`CHK("sel_change", 1'b1, (v1 >= 16'd100) && (v1 <= 16'd112))
		wr(IDX_CLK, 8'h00);
		wr(IDX_SC, 8'h00);
		dbg_halt <= 1'b1;
		cnt(v1);
		repeat (20) @(posedge hclk);
		cnt(v2);
		`CHK("debug_stop", v1, v2)
		wr(IDX_MODULO_LOW_BYTE, 8'h20);
		rd(IDX_MODULO_LOW_BYTE, d);
		`CHK("debug_mod", 8'h20, d)
		rd(IDX_COUNT_LOW_BYTE, d);
		`CHK("debug_zero", 8'h00, d)
		dbg_halt <= 1'b0;
		wr(IDX_SC, 8'h30);
		wr(IDX_MODULO_HIGH_BYTE, 8'h00);
		wr(IDX_MODULO_LOW_BYTE, 8'h30);
		wr(IDX_MODULO_HIGH_BYTE, 8'h00);
		wr(IDX_MODULO_LOW_BYTE, 8'h08);
		rd(IDX_MODULO_LOW_BYTE, d);
		`CHK("mod_pending", 8'h30, d)
		wr(IDX_SC, 8'h00);
		repeat (100) @(posedge hclk);
		rd(IDX_MODULO_LOW_BYTE, d);
		`CHK("mod_applied", 8'h08, d)
		complete_run();
	end
endmodule : testbench
bind mtm_timer mtm_timer_chk i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .overflow_irq(overflow_irq));

// file: rtl/mtm_ahb.sv
/*
 * AHB-Lite slave for the modulo timer registers.
 * Assumes single word transfers; writes take no wait state, reads take one.
 */
`timescale 1ns/1ps
module mtm_ahb (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [mtm_pkg::HADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [mtm_pkg::HDATA_W-1:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [mtm_pkg::HDATA_W-1:0] hrdata,
	mtm_reg_if.bus rif
);
	import mtm_pkg::*;

	typedef enum logic {ST_IDLE = 1'b0, ST_RWAIT = 1'b1} mtm_bus_e;

	mtm_bus_e state_ff;
	logic wpend_ff;
	logic hit_ff;
	logic [IDX_W-1:0] idx_ff;
	logic ready_ff;
	logic [HDATA_W-1:0] rdata_ff;
	logic take;
	logic hit;

	assign take = hsel & htrans[1] & hready;
	assign hit = (haddr[HADDR_W-1:5] == '0) && (haddr[4:2] <= IDX_LAST) && (haddr[1:0] == 2'h0);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff <= ST_IDLE;
			wpend_ff <= 1'b0;
			hit_ff <= 1'b0;
			idx_ff <= '0;
			ready_ff <= 1'b1;
		end else begin
			wpend_ff <= take & hwrite;
			if (take) begin
				hit_ff <= hit;
				idx_ff <= haddr[4:2];
			end
			unique case (state_ff)
				ST_IDLE: begin
					if (take && !hwrite) begin
						state_ff <= ST_RWAIT;
						ready_ff <= 1'b0;
					end
				end
				ST_RWAIT: begin
					state_ff <= ST_IDLE;
					ready_ff <= 1'b1;
				end
			endcase
		end
	end

	// Read is sampled a cycle late so a write just ahead of it is visible
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_ff <= '0;
		end else if (state_ff == ST_RWAIT) begin
			rdata_ff <= hit_ff ? {{(HDATA_W-REG_W){1'b0}}, rif.rdata} : '0;
		end
	end

	assign rif.rd = (state_ff == ST_RWAIT) & hit_ff;
	assign rif.wr = wpend_ff & hit_ff;
	assign rif.idx = idx_ff;
	assign rif.wdata = hwdata[REG_W-1:0];
	assign hreadyout = ready_ff;
	assign hresp = 1'b0;
	assign hrdata = rdata_ff;

endmodule : mtm_ahb

// file: rtl/mtm_pkg.sv
/*
 * Constants shared by the 16-bit modulo timer: register word indices,
 * field positions, reset values and clock source codes.
 * Assumes a 32-bit AHB-Lite bus with byte-wide registers in the low lane.
 */
package mtm_pkg;

	localparam int HADDR_W = 32;
	localparam int HDATA_W = 32;
	localparam int REG_W = 8;
	localparam int CNT_W = 16;
	localparam int IDX_W = 3;

	// Word index of each register; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_SC = 3'h0;
	localparam logic [IDX_W-1:0] IDX_CLK = 3'h1;
	localparam logic [IDX_W-1:0] IDX_COUNT_HIGH_BYTE = 3'h2;
	localparam logic [IDX_W-1:0] IDX_COUNT_LOW_BYTE = 3'h3;
	localparam logic [IDX_W-1:0] IDX_MODULO_HIGH_BYTE = 3'h4;
	localparam logic [IDX_W-1:0] IDX_MODULO_LOW_BYTE = 3'h5;
	localparam logic [IDX_W-1:0] IDX_LAST = 3'h5;

	// status_control fields
	localparam int FLAG_BIT = 7;
	localparam int IRQEN_BIT = 6;
	localparam int CLEAR_BIT = 5;
	localparam int HALT_BIT = 4;

	// clock_config fields
	localparam int SRC_LSB = 4;
	localparam int SRC_W = 2;
	localparam int PRESC_LSB = 0;
	localparam int PRESC_W = 4;
	localparam logic [PRESC_W-1:0] PRESC_MAX = 4'h8;

	localparam logic [SRC_W-1:0] SRC_BUS = 2'h0;
	localparam logic [SRC_W-1:0] SRC_FIXED = 2'h1;
	localparam logic [SRC_W-1:0] SRC_EXT_FALL = 2'h2;
	localparam logic [SRC_W-1:0] SRC_EXT_RISE = 2'h3;

	localparam logic HALT_RST = 1'b1;
	localparam logic [SRC_W-1:0] SRC_RST = 2'h0;
	localparam logic [PRESC_W-1:0] PRESC_RST = 4'h0;
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
	localparam logic [CNT_W-1:0] MOD_RST = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_TOP = 16'hffff;

endpackage : mtm_pkg

// file: rtl/mtm_presc.sv
/*
 * Clock source selector and 8-bit prescaler of the modulo timer.
 * Assumes the fixed clock and the external input are asynchronous levels.
 */
`timescale 1ns/1ps
module mtm_presc #(
	parameter int DIV_W = 8
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic fixed_freq_clock,
	input wire logic ext_count_input,
	input wire logic [mtm_pkg::SRC_W-1:0] src_sel,
	input wire logic [mtm_pkg::PRESC_W-1:0] presc_sel,
	output logic tick
);
	import mtm_pkg::*;

	generate
		if (DIV_W != 8) begin : g_chk
			$error("mtm_presc: divider must be 8 bits");
		end
	endgenerate

	logic [2:0] fix_sync_ff;
	logic [2:0] ext_sync_ff;
	logic [DIV_W-1:0] div_ff;
	logic tick_ff;
	logic src_edge;

	function automatic logic [DIV_W-1:0] presc_mask(input logic [PRESC_W-1:0] code);
		logic [PRESC_W-1:0] k;
		k = (code > PRESC_MAX) ? PRESC_MAX : code;
		presc_mask = DIV_W'((9'h001 << k) - 9'h001);
	endfunction : presc_mask

	// Stage 0 feeds only stage 1; edges are taken between stages 1 and 2
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fix_sync_ff <= 3'h0;
			ext_sync_ff <= 3'h0;
		end else begin
			fix_sync_ff <= {fix_sync_ff[1:0], fixed_freq_clock};
			ext_sync_ff <= {ext_sync_ff[1:0], ext_count_input};
		end
	end

	always_comb begin
		unique case (src_sel)
			SRC_BUS: src_edge = 1'b1;
			SRC_FIXED: src_edge = fix_sync_ff[1] & ~fix_sync_ff[2];
			SRC_EXT_FALL: src_edge = ~ext_sync_ff[1] & ext_sync_ff[2];
			SRC_EXT_RISE: src_edge = ext_sync_ff[1] & ~ext_sync_ff[2];
		endcase
	end

	// Free-running so a rate change never disturbs the count
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_ff <= '0;
		end else if (src_edge) begin
			div_ff <= div_ff + 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= src_edge && ((div_ff & presc_mask(presc_sel)) == presc_mask(presc_sel));
		end
	end

	assign tick = tick_ff;

endmodule : mtm_presc

// file: rtl/mtm_reg_if.sv
/*
 * Register access strobes between the bus slave and the timer core.
 * Assumes rd and wr are one-cycle pulses in the hclk domain.
 */
`timescale 1ns/1ps
interface mtm_reg_if;
	import mtm_pkg::*;
	logic rd;
	logic wr;
	logic [IDX_W-1:0] idx;
	logic [REG_W-1:0] wdata;
	logic [REG_W-1:0] rdata;
	modport bus (output rd, output wr, output idx, output wdata, input rdata);
	modport core (input rd, input wr, input idx, input wdata, output rdata);
endinterface : mtm_reg_if

// file: rtl/mtm_timer.sv
/*
 * Top of the 16-bit modulo timer: registers, counter, overflow flag,
 * coherent count reads and buffered modulo writes.
 * Assumes debug_halt_mode comes from logic on hclk; the pins
 * fixed_freq_clock and ext_count_input are asynchronous.
 */
`timescale 1ns/1ps

module mtm_timer (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [mtm_pkg::HADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [mtm_pkg::HDATA_W-1:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [mtm_pkg::HDATA_W-1:0] hrdata,
	input wire logic debug_halt_mode,
	input wire logic fixed_freq_clock,
	input wire logic ext_count_input,
	output logic overflow_irq
);
	import mtm_pkg::*;

	mtm_reg_if rif ();

	// The count is read as two register bytes on the low lane
	generate
		if (CNT_W != 2 * REG_W) begin : g_cnt_chk
			$error("mtm_timer: count must be exactly two register bytes");
		end
		if (HDATA_W < REG_W) begin : g_lane_chk
			$error("mtm_timer: bus data narrower than a register byte");
		end
	endgenerate

	// Wrap test; modulo zero falls back to the full 16-bit range
	function automatic logic at_top(
		input logic [CNT_W-1:0] cnt_val,
		input logic [CNT_W-1:0] mod_cur
	);
		at_top = (cnt_val == CNT_TOP) || ((mod_cur != MOD_RST) && (cnt_val == mod_cur));
	endfunction : at_top

	// Picks one count byte from the coherency buffer or from the live count
	function automatic logic [REG_W-1:0] count_byte(
		input logic hi,
		input logic from_held,
		input logic [CNT_W-1:0] held_val,
		input logic [CNT_W-1:0] live_val
	);
		logic [CNT_W-1:0] src;
		src = from_held ? held_val : live_val;
		count_byte = hi ? src[CNT_W-1:REG_W] : src[REG_W-1:0];
	endfunction : count_byte

	logic overflow_flag_ff;
	logic overflow_irq_enable_ff;
	logic counter_halt_ff;
	logic clear_arm_ff;
	logic [SRC_W-1:0] clock_source_sel_ff;
	logic [PRESC_W-1:0] prescale_sel_ff;
	logic [CNT_W-1:0] count_ff;
	logic [CNT_W-1:0] rd_buf_ff;
	logic rd_held_ff;
	logic rd_first_hi_ff;
	logic [CNT_W-1:0] mod_eff_ff;
	logic [CNT_W-1:0] mod_new_ff;
	logic mod_pend_ff;
	logic [REG_W-1:0] mod_buf_hi_ff;
	logic [REG_W-1:0] mod_buf_lo_ff;
	logic [1:0] mod_seen_ff;
	logic mod_now_ff;
	logic irq_ff;

	logic tick;
	logic step;
	logic wrap;
	logic ovf;
	logic sc_wr;
	logic sc_rd;
	logic clk_wr;
	logic trst;
	logic cnt_rd;
	logic mod_hi_wr;
	logic mod_lo_wr;
	logic mod_done;
	logic dbg_mod_wr;
	logic use_held;
	logic [CNT_W-1:0] mod_val;

	mtm_ahb u_ahb (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.rif(rif.bus)
	);

	mtm_presc #(
		.DIV_W(8)
	) u_presc (
		.hclk(hclk),
		.hresetn(hresetn),
		.fixed_freq_clock(fixed_freq_clock),
		.ext_count_input(ext_count_input),
		.src_sel(clock_source_sel_ff),
		.presc_sel(prescale_sel_ff),
		.tick(tick)
	);

	// Access decode
	assign sc_wr = rif.wr && (rif.idx == IDX_SC);
	assign sc_rd = rif.rd && (rif.idx == IDX_SC);
	assign clk_wr = rif.wr && (rif.idx == IDX_CLK);
	assign trst = sc_wr && rif.wdata[CLEAR_BIT];
	assign cnt_rd = rif.rd && ((rif.idx == IDX_COUNT_HIGH_BYTE) || (rif.idx == IDX_COUNT_LOW_BYTE));
	assign mod_hi_wr = rif.wr && (rif.idx == IDX_MODULO_HIGH_BYTE);
	assign mod_lo_wr = rif.wr && (rif.idx == IDX_MODULO_LOW_BYTE);

	// Count step and wrap
	assign step = tick && !counter_halt_ff && !debug_halt_mode;
	assign wrap = at_top(count_ff, mod_eff_ff);
	// Debug reads must see the live count, so the buffer is bypassed there
	assign use_held = rd_held_ff && !debug_halt_mode;
	assign ovf = step && wrap;

	// Modulo write buffer
	assign dbg_mod_wr = debug_halt_mode && (mod_hi_wr || mod_lo_wr);
	assign mod_done = !debug_halt_mode && ((mod_hi_wr && mod_seen_ff[0]) || (mod_lo_wr && mod_seen_ff[1]));
	assign mod_val = mod_hi_wr ? {rif.wdata, mod_buf_lo_ff} : {mod_buf_hi_ff, rif.wdata};

	// Source and rate changes never touch the count
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clock_source_sel_ff <= SRC_RST;
			prescale_sel_ff <= PRESC_RST;
		end else if (clk_wr) begin
			clock_source_sel_ff <= rif.wdata[SRC_LSB +: SRC_W];
			prescale_sel_ff <= rif.wdata[PRESC_LSB +: PRESC_W];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			overflow_irq_enable_ff <= 1'b0;
			counter_halt_ff <= HALT_RST;
		end else if (sc_wr) begin
			overflow_irq_enable_ff <= rif.wdata[IRQEN_BIT];
			counter_halt_ff <= rif.wdata[HALT_BIT];
		end
	end

	// Counter; writes to the count bytes are never decoded
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_ff <= CNT_RST;
		end else if (trst || dbg_mod_wr || (mod_done && mod_now_ff)) begin
			count_ff <= CNT_RST;
		end else if (step) begin
			count_ff <= wrap ? CNT_RST : count_ff + 1'b1;
		end
	end

	// Arming read; any overflow drops it so the next zero write is harmless
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clear_arm_ff <= 1'b0;
		end else if (ovf || sc_wr || trst) begin
			clear_arm_ff <= 1'b0;
		end else if (sc_rd && overflow_flag_ff) begin
			clear_arm_ff <= 1'b1;
		end
	end

	// A new overflow beats any clear arriving in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			overflow_flag_ff <= 1'b0;
		end else if (ovf) begin
			overflow_flag_ff <= 1'b1;
		end else if (trst) begin
			overflow_flag_ff <= 1'b0;
		end else if (sc_wr && !rif.wdata[FLAG_BIT] && clear_arm_ff) begin
			overflow_flag_ff <= 1'b0;
		end
	end

	// Registered, so the request trails the flag by one cycle.
	// Software that sets the enable with the flag up gets a request at once;
	// the logic does not guard against that order.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= overflow_flag_ff && overflow_irq_enable_ff;
		end
	end

	assign overflow_irq = irq_ff;

	// Coherent count read latch.
	// Reading the same byte twice keeps the snapshot; only the other byte
	// or a counter-clear releases it, so either byte order gives one consistent value.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_held_ff <= 1'b0;
			rd_first_hi_ff <= 1'b0;
			rd_buf_ff <= CNT_RST;
		end else if (trst) begin
			rd_held_ff <= 1'b0;
		end else if (cnt_rd && !debug_halt_mode) begin
			if (!rd_held_ff) begin
				rd_held_ff <= 1'b1;
				rd_first_hi_ff <= (rif.idx == IDX_COUNT_HIGH_BYTE);
				rd_buf_ff <= count_ff;
			end else if ((rif.idx == IDX_COUNT_HIGH_BYTE) != rd_first_hi_ff) begin
				rd_held_ff <= 1'b0;
			end
		end
	end

	// Modulo write latch sequence; frozen in debug, restarted by counter-clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mod_seen_ff <= 2'h0;
			mod_buf_hi_ff <= '0;
			mod_buf_lo_ff <= '0;
		end else if (trst) begin
			mod_seen_ff <= 2'h0;
		end else if (!debug_halt_mode) begin
			if (mod_done) begin
				mod_seen_ff <= 2'h0;
			end else if (mod_hi_wr) begin
				mod_seen_ff[1] <= 1'b1;
				mod_buf_hi_ff <= rif.wdata;
			end else if (mod_lo_wr) begin
				mod_seen_ff[0] <= 1'b1;
				mod_buf_lo_ff <= rif.wdata;
			end
		end
	end

	// Set by reset and counter-clear: the next complete pair applies at once
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mod_now_ff <= 1'b1;
		end else if (trst) begin
			mod_now_ff <= 1'b1;
		end else if (mod_done) begin
			mod_now_ff <= 1'b0;
		end
	end

	// Effective modulo; a pending pair waits for the next wrap or counter-clear.
	// Applying it only at a wrap or a counter-clear keeps the running period whole; the cost is
	// one more full period at the old value after a late write.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mod_eff_ff <= MOD_RST;
			mod_new_ff <= MOD_RST;
			mod_pend_ff <= 1'b0;
		end else begin
			if ((ovf || trst) && mod_pend_ff) begin
				mod_eff_ff <= mod_new_ff;
				mod_pend_ff <= 1'b0;
			end
			if (dbg_mod_wr && mod_hi_wr) begin
				mod_eff_ff[15:8] <= rif.wdata;
			end else if (dbg_mod_wr) begin
				mod_eff_ff[7:0] <= rif.wdata;
			end else if (mod_done && mod_now_ff) begin
				mod_eff_ff <= mod_val;
			end else if (mod_done) begin
				mod_new_ff <= mod_val;
				mod_pend_ff <= 1'b1;
			end
		end
	end

	// Read data; the latch only serves reads outside debug halt
	always_comb begin
		rif.rdata = '0;
		unique case (rif.idx)
			IDX_SC: rif.rdata = {overflow_flag_ff, overflow_irq_enable_ff, 1'b0, counter_halt_ff, 4'h0};
			IDX_CLK: rif.rdata = {2'h0, clock_source_sel_ff, prescale_sel_ff};
			IDX_COUNT_HIGH_BYTE: rif.rdata = count_byte(1'b1, use_held, rd_buf_ff, count_ff);
			IDX_COUNT_LOW_BYTE: rif.rdata = count_byte(1'b0, use_held, rd_buf_ff, count_ff);
			IDX_MODULO_HIGH_BYTE: rif.rdata = mod_eff_ff[15:8];
			IDX_MODULO_LOW_BYTE: rif.rdata = mod_eff_ff[7:0];
			default: rif.rdata = '0;
		endcase
	end

endmodule : mtm_timer
